// ---- pkg/tpd_pkg.sv ----
/*
 Constants and types for the three-phase gate input decoder.
 Assumes a single clock domain; pin inputs other than the state code and dwell pins are synchronous to clk.
*/
package tpd_pkg;

    // Input mode encodings
    typedef enum logic [1:0] {
        TPD_MODE_SIX    = 2'b00,
        TPD_MODE_THREE  = 2'b01,
        TPD_MODE_SINGLE = 2'b10,
        TPD_MODE_RSVD   = 2'b11
    } tpd_mode_t;

    localparam tpd_mode_t TPD_MODE_RESET = TPD_MODE_SIX;

    // Commutation table selection
    localparam logic TPD_TBL_ACTIVE_FW = 1'b0;
    localparam logic TPD_TBL_DIODE_FW = 1'b1;
    localparam logic TPD_TBL_RESET = TPD_TBL_ACTIVE_FW;

    // Per-phase drive kind inside a commutation state
    localparam logic [1:0] TPD_PH_OFF = 2'h0;
    localparam logic [1:0] TPD_PH_PWM = 2'h1;
    localparam logic [1:0] TPD_PH_LOW = 2'h2;

    // State codes: bit0 from phase A low pin, bit1 phase B high, bit2 phase B low
    localparam logic [2:0] TPD_CODE_STOP = 3'h0;
    localparam logic [2:0] TPD_CODE_BA = 3'h1;
    localparam logic [2:0] TPD_CODE_AC = 3'h2;
    localparam logic [2:0] TPD_CODE_BC = 3'h3;
    localparam logic [2:0] TPD_CODE_CB = 3'h4;
    localparam logic [2:0] TPD_CODE_CA = 3'h5;
    localparam logic [2:0] TPD_CODE_AB = 3'h6;
    localparam logic [2:0] TPD_CODE_ALIGN = 3'h7;
    localparam logic [2:0] TPD_CODE_RESET = TPD_CODE_STOP;

    // Phase drive field positions in a 6-bit kind vector
    localparam int TPD_POS_A = 0;
    localparam int TPD_POS_B = 2;
    localparam int TPD_POS_C = 4;

    typedef struct packed {
        tpd_mode_t mode;
        logic tbl;
        logic [2:0] code_s1;
        logic [2:0] code_s2;
        logic dwell_s1;
        logic dwell_s2;
        logic [2:0] cur_code;
        logic [2:0] prev_code;
        logic in_dwell;
        logic hg_a;
        logic lg_a;
        logic hg_b;
        logic lg_b;
        logic hg_c;
        logic lg_c;
    } tpd_state_t;

endpackage

// ---- design/tpd_decoder.sv ----
/*
 Gate input decoder: turns PWM and GPIO pins into six gate-drive commands
 in six-input, three-input or single-input (table) mode with dwell states.
 Assumes pins are synchronous to clk except the state code and dwell pins,
 which are synchronised here; dead time and analog drive sit downstream.
*/
`timescale 1ns/1ps
`default_nettype none

// Function
// RULE1: Six-input, both inputs high: both gates off
// RULE2: Six-input, single high input drives matching gate
// RULE3: Three-input: high follows input, low complements
// RULE4: Three-input: low-side pins fully ignored
// RULE5: Single-input: PWM on A-high, code from pins
// RULE6: Code selects six steps, align, stop
// RULE7: PWM accepted at any duty, continuous high
// RULE8: Table outputs obey user drive settings
// RULE9: Controller holds dwell pin high during change
// RULE10: Dwell state held until dwell pin low
// RULE11: Dwell pin may stay low if unused
// RULE12: Single-input: phase C low pin ignored
// RULE13: Table chosen by configuration select field
// RULE14: Active freewheel code AB: A pwm/!pwm, B low
// RULE15: Mode from configuration field, six after reset
// RULE16: Code and dwell pins synchronised before decode
module tpd_decoder
    import tpd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    // Configuration
    input wire logic cfg_load,
    input wire logic [1:0] cfg_mode,
    input wire logic cfg_table,
    input wire logic drive_enable,
    // PWM and GPIO pins
    input wire logic phase_a_high_in,
    input wire logic phase_a_low_in,
    input wire logic phase_b_high_in,
    input wire logic phase_b_low_in,
    input wire logic dwell_request_in,
    input wire logic phase_c_low_in,
    // Gate commands
    output logic high_gate_out_a,
    output logic low_gate_out_a,
    output logic high_gate_out_b,
    output logic low_gate_out_b,
    output logic high_gate_out_c,
    output logic low_gate_out_c
);

    tpd_state_t st;
    tpd_state_t next_st;

    // Drive kinds per phase for each state code
    function automatic logic [5:0] step_kinds(input logic [2:0] code);
        logic [5:0] k;
        k = {TPD_PH_OFF, TPD_PH_OFF, TPD_PH_OFF};
        case (code) // [RULE6]
            TPD_CODE_AB: k = {TPD_PH_OFF, TPD_PH_LOW, TPD_PH_PWM}; // [RULE14]
            TPD_CODE_AC: k = {TPD_PH_LOW, TPD_PH_OFF, TPD_PH_PWM};
            TPD_CODE_BC: k = {TPD_PH_LOW, TPD_PH_PWM, TPD_PH_OFF};
            TPD_CODE_BA: k = {TPD_PH_OFF, TPD_PH_PWM, TPD_PH_LOW};
            TPD_CODE_CA: k = {TPD_PH_PWM, TPD_PH_OFF, TPD_PH_LOW};
            TPD_CODE_CB: k = {TPD_PH_PWM, TPD_PH_LOW, TPD_PH_OFF};
            TPD_CODE_ALIGN: k = {TPD_PH_LOW, TPD_PH_LOW, TPD_PH_PWM};
            default: k = {TPD_PH_OFF, TPD_PH_OFF, TPD_PH_OFF};
        endcase
        return k;
    endfunction

    // Overlap of two steps; a phase asked to both switch and clamp stays off
    function automatic logic [1:0] merge_kind(input logic [1:0] a, input logic [1:0] b);
        logic [1:0] m;
        m = TPD_PH_OFF;
        if (a == b) begin
            m = a;
        end else if (a == TPD_PH_OFF) begin
            m = b;
        end else if (b == TPD_PH_OFF) begin
            m = a;
        end
        return m;
    endfunction

    // Expand a kind into {high, low} gate levels
    function automatic logic [1:0] gates(input logic [1:0] k, input logic pwm, input logic tbl);
        logic [1:0] g;
        g = 2'h0;
        if (k == TPD_PH_PWM) begin
            g = {pwm, (tbl == TPD_TBL_ACTIVE_FW) ? ~pwm : 1'b0}; // [RULE13] [RULE7]
        end else if (k == TPD_PH_LOW) begin
            g = 2'h1;
        end
        return g;
    endfunction

    always_comb begin
        logic [5:0] kn;
        logic [5:0] kp;
        logic [5:0] kv;
        logic [1:0] ga;
        logic [1:0] gb;
        logic [1:0] gc;
        next_st = st;
        kn = 6'h0;
        kp = 6'h0;
        kv = 6'h0;
        ga = 2'h0;
        gb = 2'h0;
        gc = 2'h0;
        if (cfg_load) begin
            next_st.mode = tpd_mode_t'(cfg_mode); // [RULE15]
            next_st.tbl = cfg_table; // [RULE13]
        end
        // Two-stage synchronisers on the code and dwell pins
        next_st.code_s1 = {phase_b_low_in, phase_b_high_in, phase_a_low_in}; // [RULE5] [RULE16]
        next_st.code_s2 = st.code_s1;
        next_st.dwell_s1 = dwell_request_in;
        next_st.dwell_s2 = st.dwell_s1;
        if (st.code_s2 != st.cur_code) begin
            next_st.prev_code = st.cur_code;
            next_st.cur_code = st.code_s2;
            next_st.in_dwell = st.dwell_s2; // [RULE10]
        end else if (st.in_dwell && !st.dwell_s2) begin
            next_st.in_dwell = 1'b0; // [RULE10]
        end
        kn = step_kinds(next_st.cur_code);
        kp = step_kinds(next_st.prev_code);
        kv = kn;
        if (next_st.in_dwell) begin
            kv[1:0] = merge_kind(kp[1:0], kn[1:0]);
            kv[3:2] = merge_kind(kp[3:2], kn[3:2]);
            kv[5:4] = merge_kind(kp[5:4], kn[5:4]);
        end
        case (st.mode)
            TPD_MODE_SIX: begin
                // Both high is shoot-through, so both off [RULE1] [RULE2]
                ga = {phase_a_high_in & ~phase_a_low_in, phase_a_low_in & ~phase_a_high_in};
                gb = {phase_b_high_in & ~phase_b_low_in, phase_b_low_in & ~phase_b_high_in};
                gc = {dwell_request_in & ~phase_c_low_in, phase_c_low_in & ~dwell_request_in};
            end
            TPD_MODE_THREE: begin
                // Low pins not read here [RULE3] [RULE4]
                ga = {phase_a_high_in, ~phase_a_high_in};
                gb = {phase_b_high_in, ~phase_b_high_in};
                gc = {dwell_request_in, ~dwell_request_in};
            end
            TPD_MODE_SINGLE: begin
                // Phase C low pin never reaches this path [RULE12]
                ga = gates(kv[TPD_POS_A +: 2], phase_a_high_in, st.tbl); // [RULE5]
                gb = gates(kv[TPD_POS_B +: 2], phase_a_high_in, st.tbl);
                gc = gates(kv[TPD_POS_C +: 2], phase_a_high_in, st.tbl);
            end
            default: begin
                ga = 2'h0;
                gb = 2'h0;
                gc = 2'h0;
            end
        endcase
        if (!drive_enable) begin
            ga = 2'h0; // [RULE8]
            gb = 2'h0;
            gc = 2'h0;
        end
        {next_st.hg_a, next_st.lg_a} = ga;
        {next_st.hg_b, next_st.lg_b} = gb;
        {next_st.hg_c, next_st.lg_c} = gc;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.mode <= TPD_MODE_RESET;
            st.tbl <= TPD_TBL_RESET;
            st.cur_code <= TPD_CODE_RESET;
            st.prev_code <= TPD_CODE_RESET;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign high_gate_out_a = st.hg_a;
    assign low_gate_out_a = st.lg_a;
    assign high_gate_out_b = st.hg_b;
    assign low_gate_out_b = st.lg_b;
    assign high_gate_out_c = st.hg_c;
    assign low_gate_out_c = st.lg_c;

    sequence dwell_change_s;
        clk_en && st.mode == TPD_MODE_SINGLE && st.code_s2 != st.cur_code && st.dwell_s2;
    endsequence

    sequence dwell_hold_s;
        st.in_dwell && st.dwell_s2;
    endsequence

    six_both_off_a: assert property (@(posedge clk) disable iff (rst) // [RULE1]
        clk_en && st.mode == TPD_MODE_SIX && phase_a_high_in && phase_a_low_in
        |=> !high_gate_out_a && !low_gate_out_a)
        else $error("six-input both high did not turn phase A off");

    six_high_only_a: assert property (@(posedge clk) disable iff (rst) // [RULE2]
        clk_en && st.mode == TPD_MODE_SIX && drive_enable && phase_b_high_in && !phase_b_low_in
        |=> high_gate_out_b && !low_gate_out_b)
        else $error("six-input high only did not drive phase B high gate");

    three_compl_a: assert property (@(posedge clk) disable iff (rst) // [RULE3]
        clk_en && st.mode == TPD_MODE_THREE && drive_enable
        |=> high_gate_out_a == $past(phase_a_high_in) && low_gate_out_a != high_gate_out_a)
        else $error("three-input low gate not complement of high input");

    three_ignore_low_a: assert property (@(posedge clk) disable iff (rst) // [RULE4]
        clk_en && st.mode == TPD_MODE_THREE && drive_enable && !dwell_request_in
        |=> low_gate_out_c)
        else $error("three-input phase C low gate followed the low pin");

    sync_delay_a: assert property (@(posedge clk) disable iff (rst) // [RULE16]
        clk_en ##1 clk_en |=> st.code_s2 == $past(st.code_s1) && st.dwell_s2 == $past(st.dwell_s1))
        else $error("synchroniser stage skipped");

    dwell_enter_a: assert property (@(posedge clk) disable iff (rst) // [RULE10]
        dwell_change_s |=> st.in_dwell && st.prev_code == $past(st.cur_code))
        else $error("dwell not entered on code change with request high");

    dwell_hold_a: assert property (@(posedge clk) disable iff (rst) // [RULE10]
        dwell_hold_s ##0 (!clk_en || st.code_s2 == st.cur_code) |=> st.in_dwell)
        else $error("dwell left while request still high");

    dwell_exit_a: assert property (@(posedge clk) disable iff (rst) // [RULE10]
        clk_en && st.in_dwell && !st.dwell_s2 && st.code_s2 == st.cur_code |=> !st.in_dwell)
        else $error("dwell not left after request fell");

    freewheel_ab_a: assert property (@(posedge clk) disable iff (rst) // [RULE14]
        clk_en && drive_enable && st.mode == TPD_MODE_SINGLE && st.tbl == TPD_TBL_ACTIVE_FW
        && next_st.cur_code == TPD_CODE_AB && !next_st.in_dwell
        |=> high_gate_out_a == $past(phase_a_high_in) && low_gate_out_a == !high_gate_out_a
        && low_gate_out_b && !high_gate_out_b && !high_gate_out_c && !low_gate_out_c)
        else $error("active freewheel step AB drive wrong");

    drive_gate_a: assert property (@(posedge clk) disable iff (rst) // [RULE8]
        clk_en && !drive_enable |=> !high_gate_out_a && !low_gate_out_a && !high_gate_out_b
        && !low_gate_out_b && !high_gate_out_c && !low_gate_out_c)
        else $error("gates driven while drive disabled");

endmodule

`default_nettype wire

// ---- sim/tpd_mcu_model.sv ----
/*
 Controller model: drives the decoder's PWM and GPIO pins.
 Assumes the caller invokes its tasks from the clk domain; pins change by
 non-blocking assignment just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none

module tpd_mcu_model (
    // Clock
    input wire logic clk,
    // Pins toward the decoder
    output logic phase_a_high_in,
    output logic phase_a_low_in,
    output logic phase_b_high_in,
    output logic phase_b_low_in,
    output logic dwell_request_in,
    output logic phase_c_low_in
);
    initial begin
        {phase_a_high_in, phase_a_low_in, phase_b_high_in} = 3'h0;
        {phase_b_low_in, dwell_request_in, phase_c_low_in} = 3'h0;
    end

    // Order: a high, a low, b high, b low, c high (dwell), c low
    task automatic drive_pins(input logic [5:0] p);
        @(posedge clk);
        {phase_a_high_in, phase_a_low_in, phase_b_high_in} <= p[5:3];
        {phase_b_low_in, dwell_request_in, phase_c_low_in} <= p[2:0];
    endtask

    task automatic send_code(input logic [2:0] code, input logic pwm, input logic dwell,
                             input logic c_low);
        // Dwell raised an edge early so it is already high when the code moves
        if (dwell) begin
            @(posedge clk);
            dwell_request_in <= 1'b1;
        end
        @(posedge clk);
        phase_a_high_in <= pwm;
        {phase_b_low_in, phase_b_high_in, phase_a_low_in} <= code;
        dwell_request_in <= dwell;
        phase_c_low_in <= c_low;
    endtask
endmodule

`default_nettype wire

// ---- sim/tb_tpd_decoder.sv ----
/*
 Self-checking bench for the gate input decoder.
 Assumes one enabled edge from pin to gate, three from code pin to gate;
 all pins come from the controller model, configuration from this bench.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_tpd_decoder;
    import tpd_pkg::*;

    typedef struct packed {
        logic [1:0] mode;
        logic de;
        logic [5:0] pins;
        logic [5:0] exp;
    } tpd_row_t;

    logic clk, rst, clk_en, cfg_load, cfg_table, drive_enable;
    logic [1:0] cfg_mode;
    logic pah, pal, pbh, pbl, pdw, pcl;
    logic [5:0] gates;
    int failures = 0;
    int comparisons = 0;
    tpd_row_t rows[10] = '{
        '{2'b00, 1'b1, 6'b11_10_01, 6'b00_10_01},
        '{2'b00, 1'b1, 6'b00_01_10, 6'b00_01_10},
        '{2'b00, 1'b1, 6'b01_00_11, 6'b01_00_00},
        '{2'b00, 1'b1, 6'b10_11_00, 6'b10_00_00},
        '{2'b01, 1'b1, 6'b11_01_10, 6'b10_01_10},
        '{2'b01, 1'b1, 6'b10_00_11, 6'b10_01_10},
        '{2'b01, 1'b1, 6'b01_11_00, 6'b01_10_01},
        '{2'b01, 1'b1, 6'b00_11_01, 6'b01_10_01},
        '{2'b11, 1'b1, 6'b10_10_10, 6'b00_00_00},
        '{2'b01, 1'b0, 6'b10_10_10, 6'b00_00_00}
    };

    tpd_decoder i_tpd_decoder (.clk(clk), .rst(rst), .clk_en(clk_en), .cfg_load(cfg_load),
        .cfg_mode(cfg_mode), .cfg_table(cfg_table), .drive_enable(drive_enable),
        .phase_a_high_in(pah), .phase_a_low_in(pal), .phase_b_high_in(pbh),
        .phase_b_low_in(pbl), .dwell_request_in(pdw), .phase_c_low_in(pcl),
        .high_gate_out_a(gates[5]), .low_gate_out_a(gates[4]), .high_gate_out_b(gates[3]),
        .low_gate_out_b(gates[2]), .high_gate_out_c(gates[1]), .low_gate_out_c(gates[0]));

    tpd_mcu_model i_tpd_mcu_model (.clk(clk), .phase_a_high_in(pah), .phase_a_low_in(pal),
        .phase_b_high_in(pbh), .phase_b_low_in(pbl), .dwell_request_in(pdw),
        .phase_c_low_in(pcl));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Pwm-phase mask and low-on mask per step, gates packed a,b,c high/low
    function automatic logic [5:0] step_gates(input logic [2:0] c, input logic pwm,
                                              input logic tbl);
        logic [2:0] pm;
        logic [2:0] lm;
        logic [5:0] g;
        case (c)
            3'h6: {pm, lm} = 6'b100_010;
            3'h2: {pm, lm} = 6'b100_001;
            3'h3: {pm, lm} = 6'b010_001;
            3'h1: {pm, lm} = 6'b010_100;
            3'h5: {pm, lm} = 6'b001_100;
            3'h4: {pm, lm} = 6'b001_010;
            3'h7: {pm, lm} = 6'b100_011;
            default: {pm, lm} = 6'b000_000;
        endcase
        for (int i = 0; i < 3; i++) begin
            g[5 - 2 * i] = pm[2 - i] & pwm;
            g[4 - 2 * i] = lm[2 - i] | (pm[2 - i] & ~pwm & ~tbl);
        end
        return g;
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic chk(input logic [5:0] exp);
        @(negedge clk);
        comparisons++;
        if (gates !== exp) begin
            failures++;
            $display("mismatch at %0t: gates %b expected %b", $time, gates, exp);
        end
        // Back on a rising edge so callers drive inputs there
        @(posedge clk);
    endtask

    task automatic load_cfg(input logic [1:0] m, input logic t);
        @(posedge clk);
        cfg_mode <= m;
        cfg_table <= t;
        cfg_load <= 1'b1;
        @(posedge clk);
        cfg_load <= 1'b0;
    endtask

    task automatic finish_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        #100000;
        failures++;
        finish_test();
    end

    initial begin
        {rst, clk_en, cfg_load, cfg_table, drive_enable, cfg_mode} = 7'b1100010;
        tick(5);
        chk(6'h00);
        rst <= 1'b0;
        foreach (rows[i]) begin
            load_cfg(rows[i].mode, 1'b0);
            drive_enable <= rows[i].de;
            i_tpd_mcu_model.drive_pins(rows[i].pins);
            tick(3);
            chk(rows[i].exp);
        end
        drive_enable <= 1'b1;
        load_cfg(2'b10, 1'b0);
        for (int k = 0; k < 32; k++) begin
            load_cfg(2'b10, k[0]);
            i_tpd_mcu_model.send_code(k[4:2], k[1], 1'b0, ~k[1]);
            tick(5);
            chk(step_gates(k[4:2], k[1], k[0]));
        end
        i_tpd_mcu_model.send_code(3'h6, 1'b1, 1'b0, 1'b0);
        tick(5);
        i_tpd_mcu_model.send_code(3'h2, 1'b1, 1'b1, 1'b0);
        tick(8);
        chk(6'b10_01_01);
        i_tpd_mcu_model.send_code(3'h2, 1'b1, 1'b0, 1'b0);
        tick(5);
        chk(step_gates(3'h2, 1'b1, 1'b0));
        // Frozen clock enable must hold the gates against pin changes
        clk_en <= 1'b0;
        i_tpd_mcu_model.send_code(3'h0, 1'b1, 1'b0, 1'b0);
        tick(5);
        chk(step_gates(3'h2, 1'b1, 1'b0));
        clk_en <= 1'b1;
        rst <= 1'b1;
        tick(2);
        chk(6'h00);
        rst <= 1'b0;
        i_tpd_mcu_model.drive_pins(6'b10_00_00);
        tick(3);
        chk(6'b10_00_00);
        finish_test();
    end
endmodule

`default_nettype wire
